// ---- include/dlcp_defs.vh ----
// constants for the display link command packet framer
`ifndef DLCP_DEFS_VH
`define DLCP_DEFS_VH
// data types
`define DLCP_DT_SWR0    6'h05
`define DLCP_DT_SWR1    6'h15
`define DLCP_DT_RDREQ   6'h06
`define DLCP_DT_LWR     6'h39
`define DLCP_DT_MAXRET  6'h37
`define DLCP_DT_NULL    6'h09
`define DLCP_DT_BLANK   6'h19
`define DLCP_DT_GLWR    6'h29
`define DLCP_DT_PIX20   6'h0c
`define DLCP_DT_PIX24   6'h1c
// field position and pixel word count step
`define DLCP_PARAM_BIT  4
`define DLCP_PIX_MULT   16'h0006
// reset values
`define DLCP_MAXRET_RST 16'h0001
// parser states
`define DLCP_S_IDLE     3'h0
`define DLCP_S_H1       3'h1
`define DLCP_S_H2       3'h2
`define DLCP_S_ECC      3'h3
`define DLCP_S_PAY      3'h4
`define DLCP_S_CK0      3'h5
`define DLCP_S_CK1      3'h6
// last request kind
`define DLCP_LK_NONE    2'h0
`define DLCP_LK_WRITE   2'h1
`define DLCP_LK_READ    2'h2
// response kinds
`define DLCP_RK_ACK     2'h0
`define DLCP_RK_READ    2'h1
`define DLCP_RK_RDREP   2'h2
`define DLCP_RK_REPORT  2'h3
// error status bits
`define DLCP_E_ECCFAIL  0
`define DLCP_E_ECCCORR  1
`define DLCP_E_CKSUM    2
`define DLCP_E_WCOUNT   3
`define DLCP_E_PAD      4
`define DLCP_E_DTYPE    5
`define DLCP_E_W        6
`endif

// ---- hdl/dlcp_framer.v ----
// receive-side packet framer of the serial display link
`include "dlcp_defs.vh"

module dlcp_framer (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // byte stream from the lane receiver
    input  wire        rx_valid,
    input  wire        rx_start,
    input  wire [7:0]  rx_byte,
    input  wire        hdr_ecc_corr,
    input  wire        hdr_ecc_fail,
    input  wire        cksum_fail,
    // link control
    input  wire        link_bidir,
    input  wire        bta_req,
    input  wire        resp_done,
    input  wire        err_clear,
    // command output
    output reg         cmd_valid,
    output reg  [5:0]  cmd_type,
    output reg  [1:0]  cmd_vc,
    output reg  [7:0]  cmd_byte,
    output reg  [7:0]  cmd_param,
    output reg         rd_req,
    // long payload output
    output reg         pay_valid,
    output reg  [7:0]  pay_byte,
    output reg         pay_last,
    // pixel component output
    output reg         pix_valid,
    output reg  [11:0] pix_comp,
    output reg         pix_loose,
    // status and response
    output reg  [15:0] max_return_size,
    output reg         blank_done,
    output reg         resp_valid,
    output reg  [1:0]  resp_kind,
    output reg         bta_return,
    output reg  [5:0]  err_status
);

    // ==========================================
    // helpers
    // ==========================================
    function is_long;
        input [5:0] dt;
        begin
            is_long = (dt == `DLCP_DT_LWR) || (dt == `DLCP_DT_NULL) ||
                      (dt == `DLCP_DT_BLANK) || (dt == `DLCP_DT_GLWR) ||
                      (dt == `DLCP_DT_PIX20) || (dt == `DLCP_DT_PIX24);
        end
    endfunction

    function is_pix;
        input [5:0] dt;
        begin
            is_pix = (dt == `DLCP_DT_PIX20) || (dt == `DLCP_DT_PIX24);
        end
    endfunction

    // ==========================================
    // parser state
    // ==========================================
    reg [2:0]  st;
    reg [7:0]  di;
    reg [7:0]  hb1;
    reg [7:0]  hb2;
    reg [15:0] left;
    reg        first;
    reg [1:0]  phase;
    reg [7:0]  lo;
    reg [3:0]  hi4;
    reg [1:0]  last_kind;
    reg        tx_err;
    reg        tx_corr;
    reg        rsp_busy;
    reg [5:0]  err_set;

    wire [5:0]  dt     = di[5:0];
    wire [15:0] wc     = {hb2, hb1};
    wire        in_ecc = rx_valid && (st == `DLCP_S_ECC);
    wire        lastb  = (left == 16'h0001);
    wire [11:0] fld1   = {rx_byte[3:0], lo};
    wire [11:0] fld2   = {rx_byte, hi4};
    wire [11:0] fld    = (phase == 2'h1) ? fld1 : fld2;
    wire        pemit  = (phase != 2'h0);

    // ==========================================
    // byte framing
    // ==========================================
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st        <= `DLCP_S_IDLE;
            di        <= 8'h00;
            hb1       <= 8'h00;
            hb2       <= 8'h00;
            left      <= 16'h0000;
            first     <= 1'b0;
            phase     <= 2'h0;
            lo        <= 8'h00;
            hi4       <= 4'h0;
        end else if (rx_valid && rx_start) begin
            di <= rx_byte;
            st <= `DLCP_S_H1;
        end else if (rx_valid) begin
            case (st)
                `DLCP_S_H1: begin
                    hb1 <= rx_byte;
                    st  <= `DLCP_S_H2;
                end
                `DLCP_S_H2: begin
                    hb2 <= rx_byte;
                    st  <= `DLCP_S_ECC;
                end
                `DLCP_S_ECC: begin
                    left  <= wc;
                    first <= 1'b1;
                    phase <= 2'h0;
                    if (!is_long(dt) || hdr_ecc_fail)
                        st <= `DLCP_S_IDLE;
                    else if (wc == 16'h0000)
                        st <= `DLCP_S_CK0;
                    else
                        st <= `DLCP_S_PAY;
                end
                `DLCP_S_PAY: begin
                    left  <= left - 16'h0001;
                    first <= 1'b0;
                    // components arrive lsb first
                    case (phase)
                        2'h0: begin
                            lo    <= rx_byte;
                            phase <= 2'h1;
                        end
                        2'h1: begin
                            hi4   <= rx_byte[7:4];
                            phase <= 2'h2;
                        end
                        default: phase <= 2'h0;
                    endcase
                    if (lastb)
                        st <= `DLCP_S_CK0;
                end
                `DLCP_S_CK0: st <= `DLCP_S_CK1;
                `DLCP_S_CK1: st <= `DLCP_S_IDLE;
                default:     st <= `DLCP_S_IDLE;
            endcase
        end
    end

    // ==========================================
    // packet actions
    // ==========================================
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_valid       <= 1'b0;
            cmd_type        <= 6'h00;
            cmd_vc          <= 2'h0;
            cmd_byte        <= 8'h00;
            cmd_param       <= 8'h00;
            rd_req          <= 1'b0;
            pay_valid       <= 1'b0;
            pay_byte        <= 8'h00;
            pay_last        <= 1'b0;
            pix_valid       <= 1'b0;
            pix_comp        <= 12'h000;
            pix_loose       <= 1'b0;
            max_return_size <= `DLCP_MAXRET_RST;
            blank_done      <= 1'b0;
            err_set         <= 6'h00;
        end else begin
            cmd_valid  <= 1'b0;
            rd_req     <= 1'b0;
            pay_valid  <= 1'b0;
            pay_last   <= 1'b0;
            pix_valid  <= 1'b0;
            blank_done <= 1'b0;
            err_set    <= 6'h00;
            if (in_ecc) begin
                err_set[`DLCP_E_ECCFAIL] <= hdr_ecc_fail;
                err_set[`DLCP_E_ECCCORR] <= hdr_ecc_corr;
                cmd_type <= dt;
                cmd_vc   <= di[7:6];
            end
            if (in_ecc && !hdr_ecc_fail) begin
                case (dt)
                    `DLCP_DT_SWR0, `DLCP_DT_SWR1: begin
                        cmd_valid <= 1'b1;
                        cmd_byte  <= hb1;
                        // only a flagged parameter is taken
                        cmd_param <= dt[`DLCP_PARAM_BIT] ? hb2 : 8'h00;
                    end
                    `DLCP_DT_RDREQ: begin
                        rd_req    <= 1'b1;
                        cmd_byte  <= hb1;
                        cmd_param <= 8'h00;
                    end
                    `DLCP_DT_MAXRET: begin
                        // lsb first; dropped on one-way link
                        if (link_bidir)
                            max_return_size <= wc;
                    end
                    default: begin
                        if (!is_long(dt))
                            err_set[`DLCP_E_DTYPE] <= 1'b1;
                        // pixel word count must be 6..65532 step 6
                        if (is_pix(dt) && (wc == 16'h0000 || (wc % `DLCP_PIX_MULT) != 16'h0000))
                            err_set[`DLCP_E_WCOUNT] <= 1'b1;
                    end
                endcase
            end
            if (rx_valid && !rx_start && st == `DLCP_S_PAY) begin
                case (dt)
                    `DLCP_DT_LWR: begin
                        // first byte is the command, rest is payload
                        if (first) begin
                            cmd_valid <= 1'b1;
                            cmd_byte  <= rx_byte;
                            cmd_param <= 8'h00;
                        end else begin
                            pay_valid <= 1'b1;
                            pay_byte  <= rx_byte;
                            pay_last  <= lastb;
                        end
                    end
                    `DLCP_DT_GLWR: begin
                        pay_valid <= 1'b1;
                        pay_byte  <= rx_byte;
                        pay_last  <= lastb;
                    end
                    `DLCP_DT_PIX20, `DLCP_DT_PIX24: begin
                        // 12-bit fields from three bytes
                        if (pemit) begin
                            pix_valid <= 1'b1;
                            pix_loose <= (dt == `DLCP_DT_PIX20);
                            if (dt == `DLCP_DT_PIX20) begin
                                pix_comp <= {2'b00, fld[11:2]};
                                if (fld[1:0] != 2'b00)
                                    err_set[`DLCP_E_PAD] <= 1'b1;
                            end else begin
                                pix_comp <= fld;
                            end
                        end
                    end
                    default: ; // null and blanking payload dropped
                endcase
            end
            if (rx_valid && !rx_start && st == `DLCP_S_CK1) begin
                err_set[`DLCP_E_CKSUM] <= cksum_fail;
                blank_done <= (dt == `DLCP_DT_BLANK);
            end
        end
    end

    // ==========================================
    // turnaround response
    // ==========================================
    wire cur_err = err_set[`DLCP_E_ECCFAIL] | err_set[`DLCP_E_CKSUM] |
                   err_set[`DLCP_E_WCOUNT] | err_set[`DLCP_E_PAD] |
                   err_set[`DLCP_E_DTYPE];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            last_kind  <= `DLCP_LK_NONE;
            tx_err     <= 1'b0;
            tx_corr    <= 1'b0;
            rsp_busy   <= 1'b0;
            resp_valid <= 1'b0;
            resp_kind  <= `DLCP_RK_ACK;
            bta_return <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            bta_return <= 1'b0;
            if (cmd_valid && (cmd_type == `DLCP_DT_SWR0 || cmd_type == `DLCP_DT_SWR1))
                last_kind <= `DLCP_LK_WRITE;
            if (rd_req)
                last_kind <= `DLCP_LK_READ;
            if (cur_err)
                tx_err <= 1'b1;
            if (err_set[`DLCP_E_ECCCORR])
                tx_corr <= 1'b1;
            if (bta_req && !rsp_busy) begin
                // one-way link: turnaround not answered, pending kind and errors still cleared
                // a dropped header still earns an error report
                if (link_bidir && (last_kind != `DLCP_LK_NONE || tx_err)) begin
                    resp_valid <= 1'b1;
                    rsp_busy   <= 1'b1;
                    if (last_kind != `DLCP_LK_READ)
                        resp_kind <= (tx_err || tx_corr) ? `DLCP_RK_REPORT : `DLCP_RK_ACK;
                    else if (tx_err)
                        resp_kind <= `DLCP_RK_REPORT;
                    else if (tx_corr)
                        resp_kind <= `DLCP_RK_RDREP;
                    else
                        resp_kind <= `DLCP_RK_READ;
                end
                last_kind <= `DLCP_LK_NONE;
                tx_err    <= 1'b0;
                tx_corr   <= 1'b0;
            end
            if (rsp_busy && resp_done) begin
                rsp_busy   <= 1'b0;
                bta_return <= 1'b1;
            end
        end
    end

    // ==========================================
    // sticky error status, set wins over clear
    // ==========================================
    always @(posedge clk or posedge rst) begin
        if (rst)
            err_status <= 6'h00;
        else
            err_status <= (err_status & {6{~err_clear}}) | err_set;
    end

endmodule

// ---- tb/dlcp_framer_sva.sv ----
// concurrent checks on the ports of the display link framer
`include "dlcp_defs.vh"
module dlcp_framer_sva (
    // clock and reset
    input logic        clk,
    input logic        rst,
    // inputs
    input logic        rx_valid,
    input logic        link_bidir,
    input logic        bta_req,
    input logic        resp_done,
    // outputs
    input logic        cmd_valid,
    input logic [5:0]  cmd_type,
    input logic [7:0]  cmd_param,
    input logic        rd_req,
    input logic        pay_valid,
    input logic        pay_last,
    input logic        pix_valid,
    input logic [11:0] pix_comp,
    input logic        pix_loose,
    input logic [15:0] max_return_size,
    input logic        resp_valid,
    input logic        bta_return
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ============================================
    // assertions
    chk_maxret_reset: assert property ($fell(rst) |-> max_return_size == 16'h0001)
        else $error("return size not one after reset");
    chk_maxret_unidir: assert property (!link_bidir |=> $stable(max_return_size))
        else $error("return size changed on one-way link");
    chk_resp_cause: assert property (resp_valid |-> $past(bta_req) && link_bidir)
        else $error("response without turnaround");
    chk_unidir_bta: assert property (bta_req && !link_bidir |=> !resp_valid)
        else $error("turnaround answered on one-way link");
    chk_bta_return: assert property (resp_done |=> bta_return)
        else $error("bus not handed back");
    chk_rd_type: assert property (rd_req |-> cmd_type == `DLCP_DT_RDREQ && $past(rx_valid))
        else $error("read request of wrong type");
    chk_param_zero: assert property (cmd_valid && cmd_type == `DLCP_DT_SWR0 |-> cmd_param == 8'h00)
        else $error("parameter not zero");
    chk_pay_end: assert property (pay_last |-> pay_valid ##1 !pay_valid)
        else $error("payload runs past last byte");
    chk_loose_pad: assert property (pix_valid && pix_loose |-> pix_comp[11:10] == 2'b00)
        else $error("loose component too wide");
    chk_pix_kind: assert property (pix_valid |-> pix_loose == (cmd_type == `DLCP_DT_PIX20))
        else $error("pixel format mismatch");
    // ============================================
    // covers
    cov_cmd: cover property (cmd_valid);
    cov_resp: cover property (resp_valid ##[1:20] bta_return);
    cov_pix: cover property (pix_valid && pix_loose);
endmodule

// ---- tb/dlcp_host_model.sv ----
// host-side packet source model for the display link framer
module dlcp_host_model (
    // clock
    input  logic       clk,
    // byte stream and turnaround request toward the framer
    output logic       rx_valid,
    output logic       rx_start,
    output logic [7:0] rx_byte,
    output logic       hdr_ecc_corr,
    output logic       hdr_ecc_fail,
    output logic       cksum_fail,
    output logic       bta_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rx_valid, rx_start, hdr_ecc_corr, hdr_ecc_fail, cksum_fail, bta_req} = 6'h00;
        rx_byte = 8'h00;
    end
    // e carries {uncorrectable, corrected} for the ecc byte
    task put(input logic [7:0] b, input logic s, input logic [1:0] e);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_start <= s;
        rx_byte <= b;
        {hdr_ecc_fail, hdr_ecc_corr} <= e;
    endtask
    task idle();
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
    endtask
    task short_pkt(input logic [7:0] id, input logic [7:0] b1, input logic [7:0] b2, input logic [1:0] e);
        put(id, 1'b1, 2'b00);
        put(b1, 1'b0, 2'b00);
        put(b2, 1'b0, 2'b00);
        put(8'h5a, 1'b0, e);
        idle();
    endtask
    // payload byte i is p0 + i * k
    task long_pkt(input logic [7:0] id, input logic [15:0] wc, input logic [7:0] p0, input logic [7:0] k);
        put(id, 1'b1, 2'b00);
        put(wc[7:0], 1'b0, 2'b00);
        put(wc[15:8], 1'b0, 2'b00);
        put(8'h5a, 1'b0, 2'b00);
        for (int i = 0; i < wc; i++) put(p0 + 8'(i) * k, 1'b0, 2'b00);
        put(8'hc3, 1'b0, 2'b00);
        put(8'h3c, 1'b0, 2'b00);
        idle();
    endtask
    // turnaround only after the last packet of a transmission
    task bta();
        @(posedge clk);
        bta_req <= 1'b1;
        @(posedge clk);
        bta_req <= 1'b0;
    endtask
endmodule

// ---- tb/dlcp_framer_tb.sv ----
// self-checking testbench of the display link framer
`include "dlcp_defs.vh"
module dlcp_framer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, link_bidir = 1'b1, resp_done = 1'b0, err_clear = 1'b0;
    logic        rx_valid, rx_start, hdr_ecc_corr, hdr_ecc_fail, cksum_fail, bta_req;
    logic [7:0]  rx_byte, cmd_byte, cmd_param, pay_byte;
    logic        cmd_valid, rd_req, pay_valid, pay_last, pix_valid, pix_loose, blank_done;
    logic        resp_valid, bta_return;
    logic [5:0]  cmd_type, err_status;
    logic [1:0]  cmd_vc, resp_kind;
    logic [11:0] pix_comp;
    logic [15:0] max_return_size;
    logic [4:0]  got = 5'h00;
    logic [8:0]  pq[$];
    logic [11:0] xq[$];
    int          num_errors = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    dlcp_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_start(rx_start), .rx_byte(rx_byte),
        .hdr_ecc_corr(hdr_ecc_corr), .hdr_ecc_fail(hdr_ecc_fail), .cksum_fail(cksum_fail), .bta_req(bta_req));
    dlcp_framer dut_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_start(rx_start), .rx_byte(rx_byte),
        .hdr_ecc_corr(hdr_ecc_corr), .hdr_ecc_fail(hdr_ecc_fail), .cksum_fail(cksum_fail),
        .link_bidir(link_bidir), .bta_req(bta_req), .resp_done(resp_done), .err_clear(err_clear),
        .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_vc(cmd_vc), .cmd_byte(cmd_byte), .cmd_param(cmd_param),
        .rd_req(rd_req), .pay_valid(pay_valid), .pay_byte(pay_byte), .pay_last(pay_last), .pix_valid(pix_valid),
        .pix_comp(pix_comp), .pix_loose(pix_loose), .max_return_size(max_return_size), .blank_done(blank_done),
        .resp_valid(resp_valid), .resp_kind(resp_kind), .bta_return(bta_return), .err_status(err_status));
    // pulses are latched so a wait never misses one
    always @(posedge clk) begin
        got <= got | {blank_done, bta_return, resp_valid, rd_req, cmd_valid};
        if (pay_valid) pq.push_back({pay_last, pay_byte});
        if (pix_valid) xq.push_back(pix_comp);
    end
    // ============================================
    // helpers
    task wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_got(input int k);
        int n;
        n = 0;
        while (got[k] !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (got[k] !== 1'b1) begin
            num_errors++;
            $display("[ERR] pulse %0d expected 1 seen 0", k);
            wrap_up();
        end
        got[k] = 1'b0;
    endtask
    task settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task do_reset();
        @(posedge clk) rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    task turn(input logic [1:0] k);
        host_u.bta();
        wait_got(2);
        chk("resp_kind", 16'(k), 16'(resp_kind));
        @(posedge clk) resp_done <= 1'b1;
        @(posedge clk) resp_done <= 1'b0;
        wait_got(3);
    endtask
    function automatic logic [11:0] pix_exp(input logic [7:0] p0, input logic [7:0] k, input int j, input logic lo);
        logic [7:0]  b0, b1, b2;
        logic [11:0] f;
        b0 = p0 + 8'(3 * (j / 2)) * k;
        b1 = b0 + k;
        b2 = b1 + k;
        f = (j % 2) ? {b2, b1[7:4]} : {b1[3:0], b0};
        return lo ? {2'b00, f[11:2]} : f;
    endfunction
    // ============================================
    // scenarios
    task t_maxret();
        chk("max_reset", 16'h0001, max_return_size);
        host_u.short_pkt({2'h0, `DLCP_DT_MAXRET}, 8'h34, 8'h12, 2'b00);
        settle();
        chk("max_set", 16'h1234, max_return_size);
        @(posedge clk) link_bidir <= 1'b0;
        host_u.short_pkt({2'h0, `DLCP_DT_MAXRET}, 8'h02, 8'h00, 2'b00);
        host_u.short_pkt({2'h0, `DLCP_DT_SWR0}, 8'h11, 8'h00, 2'b00);
        settle();
        chk("max_oneway", 16'h1234, max_return_size);
        got = 5'h00;
        host_u.bta();
        settle();
        chk("resp_oneway", 16'h0000, 16'(got[2]));
        @(posedge clk) link_bidir <= 1'b1;
        do_reset();
        #1;
        chk("max_rerst", 16'h0001, max_return_size);
    endtask
    task t_short();
        got = 5'h00;
        host_u.short_pkt({2'h1, `DLCP_DT_SWR1}, 8'h36, 8'ha5, 2'b00);
        wait_got(0);
        chk("cmd_byte", 16'h0036, 16'(cmd_byte));
        chk("cmd_param", 16'h00a5, 16'(cmd_param));
        chk("cmd_vc", 16'h0001, 16'(cmd_vc));
        chk("cmd_type", 16'(`DLCP_DT_SWR1), 16'(cmd_type));
        host_u.short_pkt({2'h0, `DLCP_DT_SWR0}, 8'h29, 8'h00, 2'b00);
        wait_got(0);
        chk("cmd_param0", 16'h0000, 16'(cmd_param));
        turn(`DLCP_RK_ACK);
        host_u.short_pkt({2'h0, `DLCP_DT_SWR0}, 8'h28, 8'h00, 2'b10);
        turn(`DLCP_RK_REPORT);
    endtask
    task t_read();
        got = 5'h00;
        host_u.short_pkt({2'h0, `DLCP_DT_RDREQ}, 8'h0a, 8'h00, 2'b00);
        wait_got(1);
        chk("rd_cmd", 16'h000a, 16'(cmd_byte));
        turn(`DLCP_RK_READ);
        host_u.short_pkt({2'h0, `DLCP_DT_RDREQ}, 8'h0b, 8'h00, 2'b01);
        wait_got(1);
        turn(`DLCP_RK_RDREP);
        host_u.short_pkt({2'h0, `DLCP_DT_RDREQ}, 8'h0c, 8'h00, 2'b10);
        turn(`DLCP_RK_REPORT);
    endtask
    task t_long();
        got = 5'h00;
        pq.delete();
        host_u.long_pkt({2'h0, `DLCP_DT_LWR}, 16'h0003, 8'h40, 8'h01);
        settle();
        chk("lw_cmd", 16'h0040, 16'(cmd_byte));
        host_u.long_pkt({2'h0, `DLCP_DT_GLWR}, 16'h0002, 8'h80, 8'h01);
        host_u.long_pkt({2'h0, `DLCP_DT_NULL}, 16'h0002, 8'h00, 8'h01);
        host_u.long_pkt({2'h0, `DLCP_DT_BLANK}, 16'h0001, 8'h00, 8'h01);
        settle();
        chk("blank_done", 16'h0001, 16'(got[4]));
        chk("pay_count", 16'h0004, 16'(pq.size()));
        for (int i = 0; i < 4; i++) chk("pay_byte", {7'h00, i[0], 8'(i < 2 ? 8'h41 + i : 8'h7e + i)}, 16'(pq[i]));
    endtask
    task t_pix();
        @(posedge clk) err_clear <= 1'b1;
        @(posedge clk) err_clear <= 1'b0;
        xq.delete();
        host_u.long_pkt({2'h0, `DLCP_DT_PIX24}, 16'h0006, 8'h10, 8'h01);
        host_u.long_pkt({2'h0, `DLCP_DT_PIX20}, 16'h0006, 8'h0c, 8'h40);
        settle();
        chk("pix_count", 16'h0008, 16'(xq.size()));
        for (int j = 0; j < 8; j++) chk("pix_comp", 16'(pix_exp(j < 4 ? 8'h10 : 8'h0c, j < 4 ? 8'h01 : 8'h40, j % 4, j >= 4)), 16'(xq[j]));
        chk("err_clean", 16'h0000, 16'(err_status));
        host_u.long_pkt({2'h0, `DLCP_DT_PIX24}, 16'h0005, 8'h20, 8'h01);
        settle();
        chk("wc_error", 16'h0001, 16'(err_status[`DLCP_E_WCOUNT]));
    endtask
    initial begin
        do_reset();
        #1;
        t_maxret();
        t_short();
        t_read();
        t_long();
        t_pix();
        wrap_up();
    end
endmodule
bind dlcp_framer dlcp_framer_sva chk_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .link_bidir(link_bidir),
    .bta_req(bta_req), .resp_done(resp_done), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_param(cmd_param),
    .rd_req(rd_req), .pay_valid(pay_valid), .pay_last(pay_last), .pix_valid(pix_valid), .pix_comp(pix_comp),
    .pix_loose(pix_loose), .max_return_size(max_return_size), .resp_valid(resp_valid), .bta_return(bta_return));
